//--- rtl/baud_gen_pkg.sv
// package for the serial baud rate generator: register map, field positions, reset values
// assumes a 32-bit apb slave, one register per aligned word
`default_nettype none
package baud_gen_pkg;
  // register byte addresses: printed offsets are not all multiples of four,
  // so each is an index and the byte address is four times it
  localparam logic [11:0] RCS_IDX     = 12'h018;  // receive control and status index
  localparam logic [11:0] TCS_IDX     = 12'h098;  // transmit control and status index
  localparam logic [11:0] DIV_IDX     = 12'h099;  // baud divisor index
  localparam logic [11:0] STAT_IDX    = 12'h09a;  // generator status index
  localparam logic [13:0] RCS_ADDR    = {RCS_IDX, 2'b00};
  localparam logic [13:0] TCS_ADDR    = {TCS_IDX, 2'b00};
  localparam logic [13:0] DIV_ADDR    = {DIV_IDX, 2'b00};
  localparam logic [13:0] STAT_ADDR   = {STAT_IDX, 2'b00};
  // field positions in transmit control and status
  localparam int          CLK_SRC_BIT = 7;        // clock source select, 1 = master
  localparam int          MODE_BIT    = 4;        // 1 = synchronous, 0 = asynchronous
  localparam int          HS_BIT      = 2;        // high speed select
  localparam int          EMPTY_BIT   = 1;        // shifter empty, read only
  localparam int          UNUSED_BIT  = 3;        // unimplemented, reads zero
  // reset values
  localparam logic [7:0]  TCS_RST     = 8'h02;
  localparam logic [7:0]  RCS_RST     = 8'h00;
  localparam logic [7:0]  DIV_RST     = 8'h00;
  // prescale terminal counts (period minus one) in oscillator cycles
  localparam logic [5:0]  PRE_ASYNC_LO = 6'h3f;   // divide by 64
  localparam logic [5:0]  PRE_ASYNC_HI = 6'h0f;   // divide by 16
  localparam logic [5:0]  PRE_SYNC     = 6'h03;   // divide by 4
  // oversample prescale: one sample period is one whole tick of the x16 or x64 tick stream
  localparam logic [5:0]  PRE_RST      = 6'h00;
  localparam logic [7:0]  CNT_RST      = 8'h00;
endpackage : baud_gen_pkg
`default_nettype wire

//--- rtl/baud_prescaler.sv
// prescaler: counts oscillator cycles down a selectable period and pulses at the end
// assumes a synchronous active low reset and a restart pulse from the divisor write
`default_nettype none
module baud_prescaler (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       restart,
  input  wire logic [5:0] period_m1,
  output logic            tick
);
  logic [5:0] cnt_r;    // cycles remaining in the prescale period
  logic       tick_r;   // terminal pulse

  // count down, reload at zero or on restart
  always_ff @(posedge clk)
  begin
    if (!rst_b || restart)
    begin
      cnt_r  <= period_m1;
      tick_r <= 1'b0;
    end
    else if (cnt_r == baud_gen_pkg::PRE_RST)
    begin
      cnt_r  <= period_m1;  // new mode takes effect on the next period
      tick_r <= 1'b1;
    end
    else
    begin
      cnt_r  <= cnt_r - 6'h01;
      tick_r <= 1'b0;
    end
  end

  assign tick = tick_r;
endmodule : baud_prescaler
`default_nettype wire

//--- rtl/majority_sampler.sv
// three sample majority vote on the receive data pin
// assumes the pin is synchronous to the clock; takes a sample on each strobe
`default_nettype none
module majority_sampler (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic strobe,
  input  wire logic pin,
  output logic      level
);
  logic [2:0] shift_r;  // last three samples
  logic       level_r;  // voted level

  // vote of three samples, idle line is high
  function automatic logic vote3(input logic [2:0] s);
    vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : vote3

  // shift samples in on each strobe and vote over the fresh set
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      shift_r <= 3'h7;
      level_r <= 1'b1;
    end
    else if (strobe)
    begin
      shift_r <= {shift_r[1:0], pin};
      level_r <= vote3({shift_r[1:0], pin}); // RULE8
    end
  end

  assign level = level_r;
endmodule : majority_sampler
`default_nettype wire

//--- rtl/serial_baud_rate_generator.sv
// top of the serial baud rate generator: apb registers, 8-bit rate timer, rx sampling
// assumes one clock, apb master per amba rules, shifters outside consume the ticks
//
// Functional notes
// RULE1: free-running 8-bit timer, period from divisor
// RULE2: async low speed: osc over 64(X+1)
// RULE3: async high speed: osc over 16(X+1)
// RULE4: sync mode: osc over 4(X+1)
// RULE5: sync mode ignores high speed select
// RULE6: ticks only when master with internal clock; the code needs master only in sync mode and ticks in async mode either way
// RULE7: divisor write restarts the timer at once
// RULE8: rx pin sampled thrice, majority wins
// RULE9: divisor is unsigned 8-bit, 0 to 255
// RULE10: high speed select is control bit 2
// RULE11: software may prefer high speed for accuracy
// RULE12: async output is x16 or x64 tick
// RULE13: control bit 4 selects sync mode
// RULE14: terminal count emits tick, reloads divisor
`default_nettype none
module serial_baud_rate_generator (
  input  wire logic        CORE_CLK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [15:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RECEIVE_DATA_PIN,
  input  wire logic        SHIFTER_EMPTY,
  output logic             RATE_TICK,
  output logic             SAMPLE_TICK,
  output logic             RX_LEVEL,
  output logic             SYNC_MODE,
  output logic             CLOCK_MASTER
);
  // generator states, one-hot
  typedef enum logic [2:0] {
    GEN_IDLE  = 3'b001,   // sync mode slave: no ticks
    GEN_ASYNC = 3'b010,   // asynchronous, x16 or x64 output
    GEN_SYNC  = 3'b100    // synchronous master, divide by 4
  } gen_state_t;

  logic [7:0]  tcs_r;          // transmit control and status
  logic [7:0]  rcs_r;          // receive control and status
  logic [7:0]  div_r;          // baud divisor
  logic [7:0]  cnt_r;          // rate timer count
  logic        restart_r;      // one cycle restart after a divisor write
  logic        rate_tick_r;    // bit rate tick
  logic        samp_tick_r;    // oversample tick to the sampler
  logic [31:0] prdata_r;       // read data register
  logic        pready_r;       // access phase answer
  logic        pslverr_r;      // unmapped address flag
  logic        sync_r;         // registered mode output
  logic        master_r;       // registered master output
  gen_state_t  state_r;        // generator state
  gen_state_t  state_nxt;      // next generator state
  logic [5:0]  pre_period;     // prescaler period minus one
  logic        pre_tick;       // prescaler terminal pulse
  logic        rx_level;       // voted receive level
  logic        access;         // apb access phase
  logic        wr_en;          // write that takes effect this edge
  logic        div_wr;         // write to the divisor
  logic [13:0] word_addr;      // byte address in the register window

  // decode of a mapped address
  function automatic logic addr_ok(input logic [13:0] a);
    addr_ok = (a == baud_gen_pkg::RCS_ADDR) || (a == baud_gen_pkg::TCS_ADDR) ||
              (a == baud_gen_pkg::DIV_ADDR) || (a == baud_gen_pkg::STAT_ADDR);
  endfunction : addr_ok

  assign word_addr = PADDR[13:0];
  assign access    = PSEL && PENABLE && pready_r;
  assign wr_en     = access && PWRITE && PSTRB[0] && addr_ok(word_addr) && (PADDR[15:14] == 2'b00);
  assign div_wr    = wr_en && (word_addr == baud_gen_pkg::DIV_ADDR);

  // one wait state: pready rises in the second access cycle, drops after the handshake
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
      pready_r <= 1'b0;
    else if (PSEL && PENABLE && !pready_r)
      pready_r <= 1'b1;
    else
      pready_r <= 1'b0;
  end

  // slave error for unmapped addresses, shown with pready
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
      pslverr_r <= 1'b0;
    else if (PSEL && PENABLE && !pready_r)
      pslverr_r <= !addr_ok(word_addr) || (PADDR[15:14] != 2'b00);
    else
      pslverr_r <= 1'b0;
  end

  // read data captured the cycle before pready, held through the handshake
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
      prdata_r <= 32'h0000_0000;
    else if (PSEL && PENABLE && !pready_r && !PWRITE)
    begin
      unique case (word_addr)
        baud_gen_pkg::RCS_ADDR:  prdata_r <= {24'h00_0000, rcs_r};
        baud_gen_pkg::TCS_ADDR:  prdata_r <= {24'h00_0000, tcs_r};
        baud_gen_pkg::DIV_ADDR:  prdata_r <= {24'h00_0000, div_r};
        baud_gen_pkg::STAT_ADDR: prdata_r <= {24'h00_0000, state_r, rx_level, cnt_r[3:0]};
        default:                 prdata_r <= 32'h0000_0000;  // unmapped reads zero
      endcase
    end
  end

  // transmit control: writable bits, empty flag follows the shifter, bit 3 reads zero
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
      tcs_r <= baud_gen_pkg::TCS_RST;
    else
    begin
      if (wr_en && word_addr == baud_gen_pkg::TCS_ADDR)
        tcs_r <= PWDATA[7:0];   // RULE10 RULE13
      tcs_r[baud_gen_pkg::UNUSED_BIT] <= 1'b0;
      tcs_r[baud_gen_pkg::EMPTY_BIT]  <= SHIFTER_EMPTY;
    end
  end

  // receive control: stored for software, not used by the generator
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
      rcs_r <= baud_gen_pkg::RCS_RST;
    else if (wr_en && word_addr == baud_gen_pkg::RCS_ADDR)
      rcs_r <= PWDATA[7:0];
  end

  // baud divisor, full unsigned byte
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
      div_r <= baud_gen_pkg::DIV_RST;
    else if (div_wr)
      div_r <= PWDATA[7:0];   // RULE9
  end

  // restart pulse for the prescaler and timer, the cycle after the write
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
      restart_r <= 1'b0;
    else
      restart_r <= div_wr;  // RULE7
  end

  // mode selection: master clock in sync mode, always in async mode
  always_comb
  begin
    state_nxt = GEN_ASYNC;
    if (tcs_r[baud_gen_pkg::MODE_BIT] && !tcs_r[baud_gen_pkg::CLK_SRC_BIT])
      state_nxt = GEN_IDLE;   // RULE6
    else if (tcs_r[baud_gen_pkg::MODE_BIT])
      state_nxt = GEN_SYNC;   // RULE13
  end

  // generator state register
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
      state_r <= GEN_ASYNC;
    else
      state_r <= state_nxt;
  end

  // prescale period from mode; high speed only counts in async
  always_comb
  begin
    pre_period = baud_gen_pkg::PRE_ASYNC_LO;
    unique case (state_r)
      GEN_SYNC:  pre_period = baud_gen_pkg::PRE_SYNC;   // RULE4 RULE5
      GEN_ASYNC: pre_period = tcs_r[baud_gen_pkg::HS_BIT] ? baud_gen_pkg::PRE_ASYNC_HI
                                                          : baud_gen_pkg::PRE_ASYNC_LO; // RULE2 RULE3
      GEN_IDLE:  pre_period = baud_gen_pkg::PRE_ASYNC_LO;
    endcase
  end

  // prescaler in front of the 8-bit timer
  baud_prescaler u_pre (
    .clk       (CORE_CLK),
    .rst_b     (RST_B),
    .restart   (restart_r),
    .period_m1 (pre_period),
    .tick      (pre_tick)
  );

  // 8-bit rate timer: counts prescale ticks, reloads from the divisor at zero
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B || restart_r)
      cnt_r <= div_r;   // RULE7
    else if (pre_tick && state_r != GEN_IDLE)
    begin
      if (cnt_r == baud_gen_pkg::CNT_RST)
        cnt_r <= div_r;   // RULE1 RULE14
      else
        cnt_r <= cnt_r - 8'h01;
    end
  end

  // bit rate tick: one cycle at terminal count, none when sync slave
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B || restart_r)
      rate_tick_r <= 1'b0;
    else
      rate_tick_r <= pre_tick && (state_r != GEN_IDLE) &&
                     (cnt_r == baud_gen_pkg::CNT_RST);   // RULE14 RULE6
  end

  // oversample tick: x16 or x64 stream in async mode feeds the sampler
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B || restart_r)
      samp_tick_r <= 1'b0;
    else
      samp_tick_r <= pre_tick && (state_r == GEN_ASYNC) &&
                     (cnt_r == baud_gen_pkg::CNT_RST);   // RULE12
  end

  // majority vote on the receive pin at each oversample tick
  majority_sampler u_samp (
    .clk    (CORE_CLK),
    .rst_b  (RST_B),
    .strobe (samp_tick_r),
    .pin    (RECEIVE_DATA_PIN),
    .level  (rx_level)
  );

  // registered mode outputs for the shifters
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
    begin
      sync_r   <= 1'b0;
      master_r <= 1'b0;
    end
    else
    begin
      sync_r   <= tcs_r[baud_gen_pkg::MODE_BIT];
      master_r <= tcs_r[baud_gen_pkg::CLK_SRC_BIT];
    end
  end

  assign PRDATA      = prdata_r;
  assign PREADY      = pready_r;
  assign PSLVERR     = pslverr_r;
  assign RATE_TICK   = rate_tick_r;
  assign SAMPLE_TICK = samp_tick_r;
  assign RX_LEVEL    = rx_level;
  assign SYNC_MODE   = sync_r;
  assign CLOCK_MASTER = master_r;
endmodule : serial_baud_rate_generator
`default_nettype wire

//--- verification/baud_checker.sv
// checker: tick spacing, restart, slave silence, rx vote, mode copies
// assumes binding to the generator top; sees its apb and tick ports
`default_nettype none
module baud_checker (
  input wire logic        CORE_CLK,
  input wire logic        RST_B,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic        RATE_TICK,
  input wire logic        SAMPLE_TICK,
  input wire logic        RX_LEVEL,
  input wire logic        SYNC_MODE,
  input wire logic        CLOCK_MASTER
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  logic        tw, dw;          // completed control and divisor writes
  logic [7:0]  tcs_r, div_r;    // shadow copies of the two registers
  logic [7:0]  slv_r;           // cycles spent in sync slave mode
  logic [1:0]  nt_r;            // ticks since the last setting change
  logic [15:0] gap_r, since_r;  // cycles since tick, since divisor write
  logic        pend_r;          // divisor written, first tick awaited
  int          per;             // expected tick period in cycles
  assign tw = PSEL && PENABLE && PREADY && PWRITE && PADDR == {2'b00, baud_gen_pkg::TCS_ADDR};
  assign dw = PSEL && PENABLE && PREADY && PWRITE && PADDR == {2'b00, baud_gen_pkg::DIV_ADDR};
  assign per = (tcs_r[4] ? 4 : (tcs_r[2] ? 16 : 64)) * (int'(div_r) + 1);
  // shadow registers follow completed writes
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_B)
      tcs_r <= baud_gen_pkg::TCS_RST;
    else if (tw)
      tcs_r <= PWDATA[7:0];
    if (!RST_B)
      div_r <= baud_gen_pkg::DIV_RST;
    else if (dw)
      div_r <= PWDATA[7:0];
  end
  // counters for period, restart and slave timing
  always_ff @(posedge CORE_CLK)
  begin
    gap_r <= RATE_TICK ? 16'h0001 : gap_r + 16'h0001;
    since_r <= dw ? 16'h0000 : since_r + 16'h0001;
    slv_r <= (tcs_r[4] && !tcs_r[7]) ? slv_r + {7'h00, slv_r != 8'hff} : 8'h00;
    if (!RST_B || tw || dw)
      nt_r <= 2'h0;
    else if (RATE_TICK && nt_r != 2'h3)
      nt_r <= nt_r + 2'h1;
    if (!RST_B || RATE_TICK)
      pend_r <= 1'b0;
    else if (dw)
      pend_r <= 1'b1;
  end
  sequence tcs_write;
    tw;
  endsequence
  chk_tick_pulse: assert property (RATE_TICK |=> !RATE_TICK)
    else $error("rate tick wider than one cycle");
  chk_async_low: assert property (
    RATE_TICK && nt_r[1] && !tcs_r[4] && !tcs_r[2] |-> gap_r == per[15:0])
    else $error("async low speed period wrong");
  chk_async_high: assert property (
    RATE_TICK && nt_r[1] && !tcs_r[4] && tcs_r[2] |-> gap_r == per[15:0])
    else $error("async high speed period wrong");
  chk_sync_rate: assert property (
    RATE_TICK && nt_r[1] && tcs_r[4] |-> gap_r == per[15:0])
    else $error("sync period wrong");
  chk_restart_bound: assert property (
    pend_r && !(tcs_r[4] && !tcs_r[7]) |-> since_r <= per + 4)
    else $error("divisor write did not restart the timer");
  chk_slave_silent: assert property (slv_r == 8'hff |-> !RATE_TICK)
    else $error("tick in sync slave mode");
  chk_rx_vote: assert property (
    $changed(RX_LEVEL) |-> $past(SAMPLE_TICK) || $past(SAMPLE_TICK, 2) || $past(SAMPLE_TICK, 3))
    else $error("rx level moved without a sample");
  chk_mode_copy: assert property (
    tcs_write |-> ##2 SYNC_MODE == tcs_r[4] && CLOCK_MASTER == tcs_r[7])
    else $error("mode outputs do not follow control");
endmodule : baud_checker
bind serial_baud_rate_generator baud_checker baud_checker_inst (.*);
`default_nettype wire

//--- verification/serial_baud_rate_generator_bench.sv
// bench: register access, tick periods, restart, slave mode, rx vote
// assumes the generator answers each apb transfer with pready
`default_nettype none
module serial_baud_rate_generator_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CORE_CLK = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
  logic        PWRITE = 1'b0, RECEIVE_DATA_PIN = 1'b1, SHIFTER_EMPTY = 1'b1;
  logic [15:0] PADDR = 16'h0000;
  logic [31:0] PWDATA = 32'h0000_0000, PRDATA, rd;
  logic [3:0]  PSTRB = 4'hf;
  logic        PREADY, PSLVERR, RATE_TICK, SAMPLE_TICK, RX_LEVEL, err;
  logic        SYNC_MODE, CLOCK_MASTER;
  int          fail_count = 0, comparisons = 0, cyc = 0, n;
  localparam logic [15:0] rcs_a = {2'b00, baud_gen_pkg::RCS_ADDR};
  localparam logic [15:0] tcs_a = {2'b00, baud_gen_pkg::TCS_ADDR};
  localparam logic [15:0] div_a = {2'b00, baud_gen_pkg::DIV_ADDR};
  localparam logic [15:0] stat_a = {2'b00, baud_gen_pkg::STAT_ADDR};
  // control, divisor and expected period for each rate case
  localparam logic [7:0] t_tcs [6] = '{8'h00, 8'h04, 8'h90, 8'h94, 8'h04, 8'h80};
  localparam logic [7:0] t_div [6] = '{8'h00, 8'h02, 8'h01, 8'h02, 8'hff, 8'h03};
  localparam int         t_per [6] = '{64, 48, 8, 12, 4096, 256};
  serial_baud_rate_generator serial_baud_rate_generator_inst (.*);
  always #4 CORE_CLK = ~CORE_CLK;
  // cycle ceiling cuts a hang short
  always @(posedge CORE_CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fail_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (fail_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer: setup, access, hold until pready
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    @(posedge CORE_CLK);
    while (PREADY !== 1'b1) @(posedge CORE_CLK);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rchk
  // skip two ticks, then measure the next tick spacing
  task automatic gap(input int exp);
    n = 0;
    repeat (2)
    begin
      @(posedge CORE_CLK);
      while (RATE_TICK !== 1'b1) @(posedge CORE_CLK);
    end
    do
    begin
      @(posedge CORE_CLK);
      n++;
    end
    while (RATE_TICK !== 1'b1);
    check(32'(n), 32'(exp));
  endtask : gap
  initial
  begin
    repeat (3) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    rchk(tcs_a, 32'h02);
    rchk(rcs_a, 32'h00);
    rchk(div_a, 32'h00);
    SHIFTER_EMPTY <= 1'b0;
    apb(1'b1, tcs_a, 32'hff);
    rchk(tcs_a, 32'hf5);
    apb(1'b1, div_a, 32'hff);
    rchk(div_a, 32'hff);
    rchk(16'h0010, 32'h0);
    check({31'h0, err}, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, tcs_a, {24'h0, t_tcs[i]});
      apb(1'b1, div_a, {24'h0, t_div[i]});
      gap(t_per[i]);
    end
    // long count in progress, then a short divisor must act at once
    apb(1'b1, tcs_a, 32'h0);
    apb(1'b1, div_a, 32'hff);
    repeat (100) @(posedge CORE_CLK);
    apb(1'b1, div_a, 32'h0);
    n = 0;
    while (RATE_TICK !== 1'b1 && n < 100)
    begin
      @(posedge CORE_CLK);
      n++;
    end
    check(32'(n < 70), 32'h1);
    // sync slave: the checker expects no ticks
    apb(1'b1, tcs_a, 32'h10);
    repeat (300) @(posedge CORE_CLK);
    // status: idle state, rx level high, timer parked at zero
    rchk(stat_a, 32'h30);
    // rx vote: a single high sample must not flip the level
    apb(1'b1, tcs_a, 32'h04);
    RECEIVE_DATA_PIN <= 1'b0;
    repeat (100) @(posedge CORE_CLK);
    check({31'h0, RX_LEVEL}, 32'h0);
    repeat (2)
    begin
      @(posedge CORE_CLK);
      while (SAMPLE_TICK !== 1'b1) @(posedge CORE_CLK);
      RECEIVE_DATA_PIN <= ~RECEIVE_DATA_PIN;
    end
    n = 0;
    repeat (48) @(posedge CORE_CLK) if (RX_LEVEL !== 1'b0) n++;
    check(32'(n), 32'h0);
    RECEIVE_DATA_PIN <= 1'b1;
    repeat (64) @(posedge CORE_CLK);
    check({31'h0, RX_LEVEL}, 32'h1);
    stop_test();
  end
endmodule : serial_baud_rate_generator_bench
`default_nettype wire
